/* File: logic/pfhp_pkg.sv */
// Shared constants, types and helper functions for the flash host port
package pfhp_pkg;

	// ----------------------------------------------------------------
	// Widths and timing
	// ----------------------------------------------------------------
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int PART_W = 2;
	localparam int NUM_PART = 4;
	localparam int BLK_W = 7;
	localparam int CLK_NS = 10;
	localparam int T_SETUP_NS = 10;
	localparam int T_WR_PULSE_NS = 50;
	localparam int T_ACC_NS = 70;
	localparam int T_HOLD_NS = 10;
	localparam int T_RECOV_NS = 20;
	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] WR_CYC = 4'((T_WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RD_CYC =
		4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
	localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RECOV_CYC = 4'((T_RECOV_NS + CLK_NS - 1) / CLK_NS);

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int CTRL_GO = 0;
	localparam int CTRL_DIR = 1;
	localparam int CTRL_RST = 2;
	localparam int CTRL_WP = 3;
	localparam int CTRL_OP_LSB = 4;
	localparam int STAT_BUSY = 0;
	localparam int STAT_REFUSED = 1;
	localparam int STAT_PART_LSB = 2;
	localparam int STAT_BLK_LSB = 4;
	localparam int STAT_RST = 11;
	localparam logic CTRL_RST_RESET = 1'b1;
	localparam logic CTRL_WP_RESET = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Array map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] MAIN_BASE = 21'h008000;
	localparam logic [BLK_W-1:0] PARAM_LAST = 7'h07;
	localparam int PLANE_LSB = 19;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_STATUS = 3'h1,
		OP_PROG = 3'h2,
		OP_ERASE = 3'h3,
		OP_OTP_CHIP = 3'h4,
		OP_SUSP = 3'h5,
		OP_RESUME = 3'h6,
		OP_DONE = 3'h7
	} pfhp_op_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_PROG = 3'h1,
		M_ERASE = 3'h2,
		M_OTP_CHIP = 3'h3,
		M_PSUSP = 3'h4,
		M_ESUSP = 3'h5
	} pfhp_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CHECK = 3'h1,
		ST_SETUP = 3'h2,
		ST_PULSE = 3'h3,
		ST_HOLD = 3'h4,
		ST_RECOV = 3'h5
	} pfhp_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic rst_n;
		logic wp_n;
	} pfhp_pins_t;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [PART_W-1:0] part_of(input logic [ADDR_W-1:0] a);
		part_of = a[ADDR_W-1:PLANE_LSB];
	endfunction : part_of

	function automatic logic [BLK_W-1:0] block_of(input logic [ADDR_W-1:0] a);
		if (a < MAIN_BASE) begin
			block_of = {4'h0, a[14:12]};
		end else begin
			block_of = 7'(a[20:15]) + PARAM_LAST;
		end
	endfunction : block_of

	// What another partition in mode m permits here
	function automatic logic op_allowed(input pfhp_mode_t m, input pfhp_op_t o);
		logic rd;
		rd = (o == OP_READ) || (o == OP_STATUS) || (o == OP_DONE);
		case (m)
			M_IDLE: op_allowed = 1'b1;
			M_PROG: op_allowed = rd || (o == OP_SUSP);
			M_ERASE: op_allowed = rd;
			M_OTP_CHIP: op_allowed = (o == OP_STATUS) || (o == OP_DONE);
			M_PSUSP: op_allowed = rd || (o == OP_SUSP);
			M_ESUSP: op_allowed = rd || (o == OP_PROG) || (o == OP_SUSP);
			default: op_allowed = 1'b0;
		endcase
	endfunction : op_allowed

	function automatic pfhp_mode_t mode_after(input pfhp_mode_t m,
		input pfhp_op_t o);
		mode_after = m;
		case (o)
			OP_PROG: mode_after = M_PROG;
			OP_ERASE: mode_after = M_ERASE;
			OP_OTP_CHIP: mode_after = M_OTP_CHIP;
			OP_SUSP: begin
				if (m == M_PROG) mode_after = M_PSUSP;
				else if (m == M_ERASE) mode_after = M_ESUSP;
			end
			OP_RESUME: begin
				if (m == M_PSUSP) mode_after = M_PROG;
				else if (m == M_ESUSP) mode_after = M_ERASE;
			end
			OP_DONE: mode_after = M_IDLE;
			default: mode_after = m;
		endcase
	endfunction : mode_after

endpackage : pfhp_pkg

/* File: logic/pfhp_mode_mem.sv */
// Per-partition mode table with registered read port
`timescale 1ns/10ps
module pfhp_mode_mem
	import pfhp_pkg::*;
#(
	parameter int DEPTH = NUM_PART
) (
	input logic sys_clk_i, // System clock
	input logic rstn_i, // Async reset, active low
	input logic clr_i, // Return all entries to idle
	input logic [PART_W-1:0] rd_idx_i, // Read index
	output pfhp_mode_t rd_data_o, // Registered read data
	input logic we_i, // Write strobe
	input logic [PART_W-1:0] wr_idx_i, // Write index
	input pfhp_mode_t wr_data_i // Write data
);

	pfhp_mode_t mem_reg [DEPTH];
	pfhp_mode_t rd_reg;

	assign rd_data_o = rd_reg;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_reg <= M_IDLE;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= M_IDLE;
			end
		end else begin
			rd_reg <= mem_reg[rd_idx_i];
			if (clr_i) begin
				for (int i = 0; i < DEPTH; i++) begin
					mem_reg[i] <= M_IDLE;
				end
			end else if (we_i) begin
				mem_reg[wr_idx_i] <= wr_data_i;
			end
		end
	end

endmodule : pfhp_mode_mem

/* File: logic/pfhp_host.sv */
// Flash host port controller: AXI4-Lite registers driving flash strobes
// What this block does
// - Hold flash reset low through power transitions
// - Only one erase or program at once
// - Commands go to address inside target block
// - Busy partition limits other partitions' operations
// - Suspended erase permits program elsewhere
`timescale 1ns/10ps
module pfhp_host
	import pfhp_pkg::*;
(
	input logic sys_clk_i, // System clock, 100 MHz
	input logic rstn_i, // Async reset, active low
	input logic [7:0] s_axi_awaddr_i, // Write address
	input logic s_axi_awvalid_i, // Write address valid
	output logic s_axi_awready_o, // Write address ready
	input logic [31:0] s_axi_wdata_i, // Write data
	input logic [3:0] s_axi_wstrb_i, // Write byte strobes
	input logic s_axi_wvalid_i, // Write data valid
	output logic s_axi_wready_o, // Write data ready
	output logic [1:0] s_axi_bresp_o, // Write response
	output logic s_axi_bvalid_o, // Write response valid
	input logic s_axi_bready_i, // Write response ready
	input logic [7:0] s_axi_araddr_i, // Read address
	input logic s_axi_arvalid_i, // Read address valid
	output logic s_axi_arready_o, // Read address ready
	output logic [31:0] s_axi_rdata_o, // Read data
	output logic [1:0] s_axi_rresp_o, // Read response
	output logic s_axi_rvalid_o, // Read data valid
	input logic s_axi_rready_i, // Read data ready
	input logic [DATA_W-1:0] data_pins_i, // Flash data pins, sensed
	output pfhp_pins_t flash_o // Flash pin drive, all registered
);

	// ----------------------------------------------------------------
	// AXI4-Lite slave handshakes
	// ----------------------------------------------------------------
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [7:0] waddr_reg, waddr_next;
	logic [31:0] wdat_reg, wdat_next, rdat_reg, rdat_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic wr_fire;
	logic wr_hit;
	logic [31:0] rd_word;
	logic rd_hit;

	assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
	assign wr_hit = (waddr_reg == REG_CTRL) || (waddr_reg == REG_ADDR) ||
		(waddr_reg == REG_WDATA) || (waddr_reg == REG_STATUS);

	always_comb begin
		awready_next = awready_reg;
		wready_next = wready_reg;
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		waddr_next = waddr_reg;
		wdat_next = wdat_reg;
		wstrb_next = wstrb_reg;
		rdat_next = rdat_reg;
		if (s_axi_awvalid_i && awready_reg) begin
			aw_got_next = 1'b1;
			awready_next = 1'b0;
			waddr_next = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready_reg) begin
			w_got_next = 1'b1;
			wready_next = 1'b0;
			wdat_next = s_axi_wdata_i;
			wstrb_next = s_axi_wstrb_i;
		end
		if (wr_fire) begin
			bvalid_next = 1'b1;
			bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready_i) begin
			bvalid_next = 1'b0;
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			awready_next = 1'b1;
			wready_next = 1'b1;
		end
		if (s_axi_arvalid_i && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rdat_next = rd_word;
			rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_reg && s_axi_rready_i) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			waddr_reg <= 8'h00;
			wdat_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			rdat_reg <= 32'h00000000;
		end else begin
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			waddr_reg <= waddr_next;
			wdat_reg <= wdat_next;
			wstrb_reg <= wstrb_next;
			rdat_reg <= rdat_next;
		end
	end

	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o = wready_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign s_axi_rdata_o = rdat_reg;

	// ----------------------------------------------------------------
	// Data pin synchroniser
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dq_s1_reg <= 16'h0000;
			dq_s2_reg <= 16'h0000;
		end else begin
			dq_s1_reg <= data_pins_i;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Control registers and bus-cycle sequencer
	// ----------------------------------------------------------------
	pfhp_state_t state_reg, state_next;
	pfhp_op_t op_reg, op_next;
	pfhp_mode_t own_reg, own_next, mem_rd, mem_wdata;
	pfhp_pins_t pins_reg, pins_next;
	logic dir_reg, dir_next, rst_reg, rst_next, wp_reg, wp_next;
	logic refused_reg, refused_next, deny_reg, deny_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wd_reg, wd_next, rd_reg, rd_next;
	logic [PART_W-1:0] part_reg, part_next, mem_rd_idx, eval_idx;
	logic [BLK_W-1:0] blk_reg, blk_next;
	logic [3:0] tmr_reg, tmr_next;
	logic [2:0] chk_reg, chk_next;
	logic mem_we, go;
	logic [31:0] wmask;

	// Register read mux
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h00000000;
		if (s_axi_araddr_i == REG_CTRL) begin
			rd_word[CTRL_DIR] = dir_reg;
			rd_word[CTRL_RST] = rst_reg;
			rd_word[CTRL_WP] = wp_reg;
			rd_word[CTRL_OP_LSB +: 3] = op_reg;
		end else if (s_axi_araddr_i == REG_ADDR) begin
			rd_word[ADDR_W-1:0] = addr_reg;
		end else if (s_axi_araddr_i == REG_WDATA) begin
			rd_word[DATA_W-1:0] = wd_reg;
		end else if (s_axi_araddr_i == REG_RDATA) begin
			rd_word[DATA_W-1:0] = rd_reg;
		end else if (s_axi_araddr_i == REG_STATUS) begin
			rd_word[STAT_BUSY] = (state_reg != ST_IDLE);
			rd_word[STAT_REFUSED] = refused_reg;
			rd_word[STAT_PART_LSB +: PART_W] = part_reg;
			rd_word[STAT_BLK_LSB +: BLK_W] = blk_reg;
			rd_word[STAT_RST] = rst_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		own_next = own_reg;
		pins_next = pins_reg;
		dir_next = dir_reg;
		rst_next = rst_reg;
		wp_next = wp_reg;
		refused_next = refused_reg;
		deny_next = deny_reg;
		addr_next = addr_reg;
		wd_next = wd_reg;
		rd_next = rd_reg;
		part_next = part_reg;
		blk_next = blk_reg;
		tmr_next = tmr_reg;
		chk_next = chk_reg;
		mem_we = 1'b0;
		mem_wdata = mode_after(own_reg, op_reg);
		mem_rd_idx = chk_reg[PART_W-1:0];
		eval_idx = 2'(chk_reg - 3'h1);
		go = 1'b0;
		wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
			{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
		// Settings change only between bus cycles
		if (wr_fire && state_reg == ST_IDLE) begin
			if (waddr_reg == REG_CTRL) begin
				if (wstrb_reg[0]) begin
					dir_next = wdat_reg[CTRL_DIR];
					rst_next = wdat_reg[CTRL_RST];
					wp_next = wdat_reg[CTRL_WP];
					op_next = pfhp_op_t'(wdat_reg[CTRL_OP_LSB +: 3]);
					go = wdat_reg[CTRL_GO];
				end
			end else if (waddr_reg == REG_ADDR) begin
				addr_next = (addr_reg & ~wmask[ADDR_W-1:0]) |
					(wdat_reg[ADDR_W-1:0] & wmask[ADDR_W-1:0]);
			end else if (waddr_reg == REG_WDATA) begin
				wd_next = (wd_reg & ~wmask[DATA_W-1:0]) |
					(wdat_reg[DATA_W-1:0] & wmask[DATA_W-1:0]);
			end
		end
		if (wr_fire && waddr_reg == REG_STATUS && wstrb_reg[0] &&
			wdat_reg[STAT_REFUSED]) begin
			refused_next = 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				if (go && rst_next) begin
					refused_next = 1'b1;
				end else if (go) begin
					part_next = part_of(addr_reg);
					blk_next = block_of(addr_reg);
					chk_next = 3'h0;
					deny_next = 1'b0;
					own_next = M_IDLE;
					state_next = ST_CHECK;
				end
			end
			ST_CHECK: begin
				// Table read is one cycle late, so index k is judged at k+1
				if (chk_reg != 3'h0) begin
					if (eval_idx == part_reg) begin
						own_next = mem_rd;
					end else if (!op_allowed(mem_rd, op_reg)) begin
						deny_next = 1'b1;
					end
				end
				chk_next = chk_reg + 3'h1;
				if (chk_reg == 3'h4) begin
					if (deny_next) begin
						refused_next = 1'b1;
						state_next = ST_IDLE;
					end else begin
						pins_next.addr = addr_reg;
						pins_next.dq = wd_reg;
						pins_next.dq_oe = dir_reg;
						pins_next.ce_n = 1'b0;
						tmr_next = SETUP_CYC - 4'h1;
						state_next = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				tmr_next = tmr_reg - 4'h1;
				if (tmr_reg == 4'h0) begin
					pins_next.we_n = !dir_reg;
					pins_next.oe_n = dir_reg;
					tmr_next = dir_reg ? WR_CYC - 4'h1 : RD_CYC - 4'h1;
					state_next = ST_PULSE;
				end
			end
			ST_PULSE: begin
				tmr_next = tmr_reg - 4'h1;
				if (tmr_reg == 4'h0) begin
					if (!dir_reg) begin
						rd_next = dq_s2_reg;
					end
					// Rising write strobe latches while select stays low
					pins_next.we_n = 1'b1;
					pins_next.oe_n = 1'b1;
					tmr_next = HOLD_CYC - 4'h1;
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				tmr_next = tmr_reg - 4'h1;
				if (tmr_reg == 4'h0) begin
					pins_next.ce_n = 1'b1;
					pins_next.dq_oe = 1'b0;
					mem_we = 1'b1;
					tmr_next = RECOV_CYC - 4'h1;
					state_next = ST_RECOV;
				end
			end
			ST_RECOV: begin
				tmr_next = tmr_reg - 4'h1;
				if (tmr_reg == 4'h0) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		pins_next.rst_n = !rst_next;
		pins_next.wp_n = !wp_next;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_READ;
			own_reg <= M_IDLE;
			pins_reg <= '{addr: '0, dq: '0, dq_oe: 1'b0, ce_n: 1'b1,
				oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0, wp_n: 1'b1};
			dir_reg <= 1'b0;
			rst_reg <= CTRL_RST_RESET;
			wp_reg <= CTRL_WP_RESET;
			refused_reg <= 1'b0;
			deny_reg <= 1'b0;
			addr_reg <= '0;
			wd_reg <= 16'h0000;
			rd_reg <= 16'h0000;
			part_reg <= 2'h0;
			blk_reg <= 7'h00;
			tmr_reg <= 4'h0;
			chk_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			own_reg <= own_next;
			pins_reg <= pins_next;
			dir_reg <= dir_next;
			rst_reg <= rst_next;
			wp_reg <= wp_next;
			refused_reg <= refused_next;
			deny_reg <= deny_next;
			addr_reg <= addr_next;
			wd_reg <= wd_next;
			rd_reg <= rd_next;
			part_reg <= part_next;
			blk_reg <= blk_next;
			tmr_reg <= tmr_next;
			chk_reg <= chk_next;
		end
	end

	assign flash_o = pins_reg;

	// Flash reset puts every partition back to read array
	pfhp_mode_mem #(
		.DEPTH(NUM_PART)
	) u_mode_mem (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.clr_i(rst_reg),
		.rd_idx_i(mem_rd_idx),
		.rd_data_o(mem_rd),
		.we_i(mem_we),
		.wr_idx_i(part_reg),
		.wr_data_i(mem_wdata)
	);

endmodule : pfhp_host

/* File: dv/pfhp_host_chk.sv */
// Flash pin timing checker bound to the host port
`timescale 1ns/10ps
module pfhp_host_chk
	import pfhp_pkg::*;
(
	input logic sys_clk_i, // System clock
	input logic rstn_i, // Async reset, active low
	input pfhp_pins_t flash_o // Flash pin drive
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	AST_RST_QUIET: assert property (
		!flash_o.rst_n |-> flash_o.ce_n && flash_o.we_n)
		else $error("flash strobed while held in reset");
	AST_DRIVE_SEL: assert property (
		flash_o.dq_oe |-> !flash_o.ce_n && flash_o.oe_n)
		else $error("host drives data outside a write cycle");
	AST_READ_GATE: assert property (
		!flash_o.oe_n |-> !flash_o.dq_oe && !flash_o.ce_n && flash_o.we_n)
		else $error("output enable without a clean read cycle");
	AST_WE_WIDTH: assert property (
		$fell(flash_o.we_n) |-> !flash_o.we_n [*5] ##1 flash_o.we_n)
		else $error("write pulse width wrong");
	AST_OE_WIDTH: assert property (
		$fell(flash_o.oe_n) |-> !flash_o.oe_n [*8] ##1 !flash_o.oe_n
			##1 flash_o.oe_n)
		else $error("read pulse width wrong");
	AST_WR_HOLD: assert property (
		$rose(flash_o.we_n) |-> !flash_o.ce_n && flash_o.dq_oe
			##1 flash_o.ce_n && !flash_o.dq_oe)
		else $error("write hold cycle wrong");
	AST_SETUP: assert property (
		$fell(flash_o.ce_n) |-> flash_o.we_n && flash_o.oe_n
			##1 (!flash_o.we_n || !flash_o.oe_n))
		else $error("strobe setup cycle wrong");
	AST_ADDR_STABLE: assert property (
		!flash_o.ce_n && !$past(flash_o.ce_n) |->
			$stable(flash_o.addr) && $stable(flash_o.dq))
		else $error("address or data moved while selected");
endmodule : pfhp_host_chk

bind pfhp_host pfhp_host_chk u_pfhp_host_chk (
	.sys_clk_i(sys_clk_i),
	.rstn_i(rstn_i),
	.flash_o(flash_o)
);

/* File: dv/pfhp_flash_model.sv */
// Behavioural flash device answering the host port strobes
`timescale 1ns/10ps
module pfhp_flash_model
	import pfhp_pkg::*;
(
	input pfhp_pins_t pins_i, // Strobes from the host
	output logic [DATA_W-1:0] dq_o // Data the device drives
);
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic armed;
	initial begin
		armed = 1'b0;
		dq_o = 16'hA5C3;
	end
	always @(negedge pins_i.rst_n) armed = 1'b0;
	always @(negedge pins_i.we_n) begin
		if (!pins_i.ce_n && pins_i.rst_n) armed = 1'b1;
	end
	// Whichever strobe rises first closes the cycle
	always @(posedge pins_i.we_n or posedge pins_i.ce_n) begin
		if (armed) begin
			armed = 1'b0;
			mem[pins_i.addr] = pins_i.dq;
		end
	end
	// Released wire flips so a stale value never passes for data
	always @(pins_i.ce_n, pins_i.oe_n, pins_i.rst_n, pins_i.addr) begin
		if (pins_i.rst_n && !pins_i.ce_n && !pins_i.oe_n) begin
			if (mem.exists(pins_i.addr)) dq_o = mem[pins_i.addr];
			else dq_o = ~pins_i.addr[15:0];
		end else begin
			dq_o = ~dq_o;
		end
	end
endmodule : pfhp_flash_model

/* File: dv/pfhp_host_tb.sv */
// Self-checking bench for the flash host port
`timescale 1ns/10ps
module pfhp_host_tb
	import pfhp_pkg::*;
;
	logic sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready, ok;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [15:0] dev_dq, pins, d;
	logic [20:0] a;
	pfhp_pins_t flash;
	integer seed, num_errors, comparisons, ce_count, m;
	integer cycles = 0;
	logic [20:0] map_a [7];
	logic [6:0] map_b [7];

	assign pins = flash.dq_oe ? flash.dq : dev_dq;
	pfhp_host u_pfhp_host (.sys_clk_i(sys_clk), .rstn_i(rstn),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .data_pins_i(pins), .flash_o(flash));
	pfhp_flash_model u_pfhp_flash_model (.pins_i(flash), .dq_o(dev_dq));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(negedge flash.ce_n) ce_count = ce_count + 1;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors = num_errors + 1;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, got);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check

	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge sys_clk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] ad);
		@(posedge sys_clk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Leaves the final status word in rd
	task automatic do_op(input logic [2:0] o, input logic [20:0] ad,
		input logic [15:0] dt);
		logic dir;
		dir = o inside {OP_PROG, OP_ERASE, OP_OTP_CHIP, OP_SUSP, OP_RESUME};
		axi_wr(REG_ADDR, 32'(ad));
		axi_wr(REG_WDATA, 32'(dt));
		axi_wr(REG_CTRL, {25'h0, o, 2'b00, dir, 1'b1});
		do axi_rd(REG_STATUS); while (rd[STAT_BUSY]);
	endtask : do_op

	// What partition 1 may do while partition 0 sits in mode md
	function automatic logic exp_ok(input integer md, input logic [2:0] o);
		logic r;
		r = o inside {OP_READ, OP_STATUS, OP_DONE};
		case (md)
			1, 4: exp_ok = r || o == OP_SUSP;
			2: exp_ok = r;
			3: exp_ok = o inside {OP_STATUS, OP_DONE};
			5: exp_ok = r || o inside {OP_PROG, OP_SUSP};
			default: exp_ok = 1'b1;
		endcase
	endfunction : exp_ok

	task automatic finish_test();
		$display("errors %0d, comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'hf4896771;
		{num_errors, comparisons, ce_count} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		map_a = '{21'h007FFF, 21'h008000, 21'h07FFFF, 21'h080000,
			21'h17FFFF, 21'h180000, 21'h1FFFFF};
		map_b = '{7'h07, 7'h08, 7'h16, 7'h17, 7'h36, 7'h37, 7'h46};
		rstn = 1'b0;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		axi_rd(REG_CTRL);
		check("ctrl reset", 32'h4, rd);
		axi_rd(REG_STATUS);
		check("status reset", 32'h800, rd);
		check("flash reset pin", 32'h0, 32'(flash.rst_n));
		// Reset bit kept set in the same write, so the start is refused
		axi_wr(REG_CTRL, {25'h0, OP_PROG, 4'h7});
		axi_rd(REG_STATUS);
		check("refused in reset", 32'h1, 32'(rd[STAT_REFUSED]));
		check("cycles in reset", 32'h0, ce_count);
		axi_wr(REG_STATUS, 32'h2);
		axi_wr(8'h14, 32'h0);
		check("unmapped write", 32'(RESP_SLVERR), 32'(resp));
		axi_wr(REG_RDATA, 32'h0);
		check("readonly write", 32'(RESP_SLVERR), 32'(resp));
		axi_rd(8'h14);
		check("unmapped read", {30'h0, RESP_SLVERR}, {rd[29:0], resp});
		axi_wr(REG_CTRL, 32'h8);
		check("protect pin", 32'h0, 32'(flash.wp_n));
		axi_wr(REG_CTRL, 32'h0);
		repeat (6) begin
			a = 21'($random(seed));
			d = 16'($random(seed));
			do_op(OP_PROG, a, d);
			do_op(OP_DONE, a, 16'h0);
			do_op(OP_READ, a, 16'h0);
			axi_rd(REG_RDATA);
			check("read back", 32'(d), rd);
		end
		for (int i = 0; i < 7; i++) begin
			do_op(OP_READ, map_a[i], 16'h0);
			check("status block", 32'(map_b[i]), 32'(rd[10:4]));
			check("status part", 32'(map_a[i][20:19]), 32'(rd[3:2]));
		end
		for (m = 0; m < 6; m++) begin
			for (int o = 0; o < 8; o++) begin
				axi_wr(REG_CTRL, 32'h4);
				axi_wr(REG_CTRL, 32'h0);
				axi_wr(REG_STATUS, 32'h2);
				if (m == 1 || m == 4) do_op(OP_PROG, 21'h010000, 16'h0);
				if (m == 2 || m == 5) do_op(OP_ERASE, 21'h010000, 16'h0);
				if (m == 3) do_op(OP_OTP_CHIP, 21'h010000, 16'h0);
				if (m >= 4) do_op(OP_SUSP, 21'h010000, 16'h0);
				a = {2'b01, 19'($random(seed))};
				ce_count = 0;
				do_op(3'(o), a, 16'h5A5A);
				ok = exp_ok(m, 3'(o));
				check("refused", 32'(!ok), 32'(rd[STAT_REFUSED]));
				check("cycles", 32'(ok), ce_count);
				check("busy part", 32'h1, 32'(rd[3:2]));
			end
		end
		finish_test();
	end
endmodule : pfhp_host_tb
